// ==== verilog/led_ctrl_map.svh ====
/*
 constants of the led driver control link: register offsets, reset values,
 general purpose field positions, timing figures and host register offsets.
 assumes a 100 MHz system clock.
*/
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

// system clock
`define MCLK_PERIOD_NS      10
// serial clock period, least
`define T_SCL_MIN_NS        2500
`define SCL_QUARTER_CYCLES  ((`T_SCL_MIN_NS + 4 * `MCLK_PERIOD_NS - 1) / (4 * `MCLK_PERIOD_NS))
// dimming rate
`define PWM_FREQ_HZ         20000
`define PWM_PERIOD_CYCLES   (1000000000 / (`PWM_FREQ_HZ * `MCLK_PERIOD_NS))

// slave addresses of the two variants, values arbitrary
`define SLAVE_ADDR_STD      7'h2A
`define SLAVE_ADDR_ALT      7'h2C

// internal register offsets
`define REG_GP_OFS          8'h10
`define REG_MAIN_OFS        8'hA0
`define REG_AUX_OFS         8'hB0
`define REG_IND_OFS         8'hC0

// reset values
`define GP_RESET            8'h20
`define MAIN_BRIGHT_RESET   5'h00
`define AUX_BRIGHT_RESET    5'h00
`define IND_BRIGHT_RESET    2'h0

// general purpose register fields
`define GP_MAIN_EN_BIT      0
`define GP_AUX_EN_BIT       1
`define GP_IND_EN_BIT       2
`define GP_MAIN5_SENSE_BIT  3
`define GP_AUX3_EN_BIT      4

// host register offsets on apb
`define HOST_CTRL_OFS       12'h000
`define HOST_CMD_OFS        12'h004
`define HOST_STATUS_OFS     12'h008
`define CTRL_GO_BIT         0
`define CTRL_HWRST_BIT      1
`define STAT_BUSY_BIT       0
`define STAT_NACK_BIT       1
`define STAT_DONE_BIT       2

`endif

// ==== verilog/led_ctrl_pkg.sv ====
/*
 types of the led driver control link: state encodings of both ends.
 assumes nothing beyond a systemverilog compiler.
*/
package led_ctrl_pkg;

   typedef enum logic [4:0] {
      DEV_IDLE = 5'h01,
      DEV_ADDR = 5'h02,
      DEV_REG  = 5'h04,
      DEV_DATA = 5'h08,
      DEV_SKIP = 5'h10
   } dev_state_t;

   typedef enum logic [3:0] {
      HST_IDLE  = 4'h1,
      HST_START = 4'h2,
      HST_BIT   = 4'h4,
      HST_STOP  = 4'h8
   } host_state_t;

endpackage

// ==== verilog/led_ctrl_if.sv ====
/*
 two-wire link between bus master and led driver, plus the hardware reset pin.
 assumes an external pull-up on the data line; the level is resolved here.
*/
`timescale 1ns/1ps
interface led_ctrl_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;
   logic reset_n;

   // wired-and with pull-up
   assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

   modport master (output scl, output m_sda_o, output m_sda_oe, output reset_n, input sda);
   modport device (input scl, input sda, input reset_n, output s_sda_o, output s_sda_oe);
endinterface

// ==== verilog/sync2.sv ====
/*
 two flip-flop synchroniser for a vector of independent levels.
 assumes each bit is a slow level or a clock far slower than mclk_i.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// ==== verilog/led_ctrl_device.sv ====
/*
 led driver end: two-wire slave, control registers, dimming and gain choice.
 assumes the master end on led_ctrl_if and comparator levels from the sinks.
*/
// The address map and register access over the two-wire link were chosen for this implementation.
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_ctrl_device #(
   parameter bit SELECT_ALT_ADDR = 1'b0,
   parameter int PWM_CYCLES      = `PWM_PERIOD_CYCLES
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   led_ctrl_if.device      link,
   input  wire logic [4:0] main_sense_low_i,
   input  wire logic [2:0] aux_sense_low_i,
   output logic      [4:0] main_sink_on_o,
   output logic      [1:0] main_level_o,
   output logic      [2:0] aux_sink_on_o,
   output logic      [1:0] aux_level_o,
   output logic            indicator_on_o,
   output logic      [1:0] indicator_level_o,
   output logic            gain_boost_o,
   output logic            bus_busy_o
);
   localparam int CW = $clog2(PWM_CYCLES);
   localparam logic [6:0] OWN_ADDR = SELECT_ALT_ADDR ? `SLAVE_ADDR_ALT : `SLAVE_ADDR_STD;

   logic                     rst_all_n;
   logic [9:0]               synced;
   logic                     scl_s;
   logic                     sda_s;
   logic                     scl_d;
   logic                     sda_d;
   logic                     scl_rise;
   logic                     scl_fall;
   logic                     start_det;
   logic                     stop_det;
   led_ctrl_pkg::dev_state_t state;
   logic [3:0]               bit_cnt;
   logic [7:0]               shift;
   logic [7:0]               reg_sel;
   logic                     ack_drive;
   logic [7:0]               gp;
   logic [4:0]               main_code;
   logic [4:0]               aux_code;
   logic [1:0]               ind_code;
   logic [CW-1:0]            pwm_cnt;
   logic [6:0]               main_dec;
   logic [6:0]               aux_dec;
   logic                     main_pwm;
   logic                     aux_pwm;
   logic                     main_en;
   logic                     aux_en;
   logic                     aux3_en;
   logic                     sense_hit;

   // reset pin
   // pin clears all but the input synchroniser
   assign rst_all_n = rst_n_i & link.reset_n;

   sync2 #(.WIDTH(10)) u_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({aux_sense_low_i, main_sense_low_i, link.sda, link.scl}),
      .q_o     (synced)
   );
   assign scl_s = synced[0];
   assign sda_s = synced[1];

   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         scl_d <= 1'b0;
         sda_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         bus_busy_o <= 1'b0;
      end else if (start_det) begin
         bus_busy_o <= 1'b1;
      end else if (stop_det) begin
         bus_busy_o <= 1'b0;
      end
   end

   // byte engine
   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         state     <= led_ctrl_pkg::DEV_IDLE;
         bit_cnt   <= 4'h0;
         shift     <= 8'h00;
         reg_sel   <= 8'h00;
         ack_drive <= 1'b0;
      end else if (start_det) begin
         state     <= led_ctrl_pkg::DEV_ADDR;
         bit_cnt   <= 4'h0;
         ack_drive <= 1'b0;
      end else if (stop_det) begin
         state     <= led_ctrl_pkg::DEV_IDLE;
         bit_cnt   <= 4'h0;
         ack_drive <= 1'b0;
      end else if (state != led_ctrl_pkg::DEV_IDLE) begin
         if (scl_rise && bit_cnt < 4'h8) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h9;
            case (state)
               led_ctrl_pkg::DEV_ADDR: begin
                  if (shift[7:1] == OWN_ADDR) begin
                     ack_drive <= 1'b1;
                     state     <= shift[0] ? led_ctrl_pkg::DEV_SKIP : led_ctrl_pkg::DEV_REG;
                  end else begin
                     state <= led_ctrl_pkg::DEV_SKIP;
                  end
               end
               led_ctrl_pkg::DEV_REG: begin
                  reg_sel   <= shift;
                  ack_drive <= 1'b1;
                  state     <= led_ctrl_pkg::DEV_DATA;
               end
               led_ctrl_pkg::DEV_DATA: begin
                  ack_drive <= 1'b1;
               end
               default: begin
                  ack_drive <= 1'b0;
               end
            endcase
         end else if (scl_fall && bit_cnt == 4'h9) begin
            ack_drive <= 1'b0;
            bit_cnt   <= 4'h0;
         end
      end
   end

   assign link.s_sda_o  = 1'b0;
   assign link.s_sda_oe = ack_drive;

   // control registers
   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         gp        <= `GP_RESET;
         main_code <= `MAIN_BRIGHT_RESET;
         aux_code  <= `AUX_BRIGHT_RESET;
         ind_code  <= `IND_BRIGHT_RESET;
      end else if (state == led_ctrl_pkg::DEV_DATA && scl_fall && bit_cnt == 4'h8
                   && !start_det && !stop_det) begin
         if (reg_sel == `REG_GP_OFS) begin
            gp <= shift;
         end else if (reg_sel == `REG_MAIN_OFS) begin
            main_code <= shift[4:0];
         end else if (reg_sel == `REG_AUX_OFS) begin
            aux_code <= shift[4:0];
         end else if (reg_sel == `REG_IND_OFS) begin
            ind_code <= shift[1:0];
         end
      end
   end

   assign main_en = gp[`GP_MAIN_EN_BIT];
   assign aux_en  = gp[`GP_AUX_EN_BIT];
   assign aux3_en = gp[`GP_AUX3_EN_BIT];

   // {analog level, duty in sixteenths}
   // mixed analog and pwm
   function automatic logic [6:0] decode(input logic [4:0] c);
      logic [6:0] r;
      r = 7'h00;
      if (c < 5'h10) begin
         r = {2'h0, 5'(c + 5'h01)};
      end else if (c < 5'h17) begin
         r = {2'h1, 5'(c - 5'h06)};
      end else if (c < 5'h1D) begin
         r = {2'h2, 5'(c - 5'h0C)};
      end else if (c == 5'h1D) begin
         r = {2'h3, 5'h0D};
      end else if (c == 5'h1E) begin
         r = {2'h3, 5'h0F};
      end else begin
         r = {2'h3, 5'h10};
      end
      return r;
   endfunction

   assign main_dec = decode(main_code);
   assign aux_dec  = decode(aux_code);

   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         pwm_cnt <= '0;
      end else if (pwm_cnt == CW'(PWM_CYCLES - 1)) begin
         pwm_cnt <= '0;
      end else begin
         pwm_cnt <= pwm_cnt + CW'(1);
      end
   end

   // compare at 32 bits: full duty equals the period, which a power-of-two period cannot hold
   assign main_pwm = 32'(pwm_cnt) < (32'(main_dec[4:0]) * 32'(PWM_CYCLES)) / 32'h10;
   assign aux_pwm  = 32'(pwm_cnt) < (32'(aux_dec[4:0]) * 32'(PWM_CYCLES)) / 32'h10;

   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         main_sink_on_o    <= 5'h00;
         main_level_o      <= 2'h0;
         aux_sink_on_o     <= 3'h0;
         aux_level_o       <= 2'h0;
         indicator_on_o    <= 1'b0;
         indicator_level_o <= 2'h0;
      end else begin
         main_sink_on_o    <= {5{main_en & main_pwm}};
         main_level_o      <= main_dec[6:5];
         aux_sink_on_o     <= {aux3_en, 2'h3} & {3{aux_en & aux_pwm}};
         aux_level_o       <= aux_dec[6:5];
         indicator_on_o    <= gp[`GP_IND_EN_BIT];
         indicator_level_o <= ind_code;
      end
   end

   assign sense_hit = |({gp[`GP_MAIN5_SENSE_BIT], 4'hF} & synced[6:2] & {5{main_en}})
                    | |({aux3_en, 2'h3} & synced[9:7] & {3{aux_en}});

   always_ff @(posedge mclk_i or negedge rst_all_n) begin
      if (!rst_all_n) begin
         gain_boost_o <= 1'b0;
      end else if (sense_hit) begin
         gain_boost_o <= 1'b1;
      end else if (!main_en && !aux_en) begin
         gain_boost_o <= 1'b0;
      end
   end
endmodule

// ==== verilog/led_ctrl_host.sv ====
/*
 bus master end: apb registers order one write of three bytes on the link.
 assumes an apb master on mclk_i and the led driver on led_ctrl_if.
*/
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_ctrl_host #(
   parameter int QUARTER = `SCL_QUARTER_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   led_ctrl_if.master       link,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o
);
   led_ctrl_pkg::host_state_t state;
   logic [7:0]  qcnt;
   logic [1:0]  phase;
   logic        tick;
   logic [3:0]  bit_idx;
   logic [1:0]  byte_idx;
   logic [7:0]  tx;
   logic [23:0] cmd;
   logic        hw_rst;
   logic        nack;
   logic        done;
   logic        ack_bad;
   logic        sda_lvl;
   logic        sda_s;
   logic        wr_acc;
   logic        go;

   sync2 #(.WIDTH(1)) u_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .d_i     (link.sda),
      .q_o     (sda_s)
   );

   // apb slave, no wait states
   assign pready_o = 1'b1;
   assign wr_acc   = psel_i & penable_i & pwrite_i;
   assign go       = wr_acc && paddr_i == `HOST_CTRL_OFS && pwdata_i[`CTRL_GO_BIT]
                     && state == led_ctrl_pkg::HST_IDLE;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else if (psel_i && !penable_i) begin
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
         if (paddr_i == `HOST_CTRL_OFS) begin
            prdata_o[`CTRL_HWRST_BIT] <= hw_rst;
         end else if (paddr_i == `HOST_CMD_OFS) begin
            prdata_o[23:0] <= cmd;
         end else if (paddr_i == `HOST_STATUS_OFS) begin
            prdata_o[`STAT_BUSY_BIT] <= state != led_ctrl_pkg::HST_IDLE;
            prdata_o[`STAT_NACK_BIT] <= nack;
            prdata_o[`STAT_DONE_BIT] <= done;
         end else begin
            pslverr_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd    <= 24'h000000;
         hw_rst <= 1'b0;
      end else if (wr_acc) begin
         if (paddr_i == `HOST_CTRL_OFS) begin
            hw_rst <= pwdata_i[`CTRL_HWRST_BIT];
         end else if (paddr_i == `HOST_CMD_OFS) begin
            cmd <= pwdata_i[23:0];
         end
      end
   end

   assign link.reset_n  = ~hw_rst;
   assign link.m_sda_o  = 1'b0;
   assign link.m_sda_oe = ~sda_lvl;

   assign tick = qcnt == 8'(QUARTER - 1);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         qcnt  <= 8'h00;
         phase <= 2'h0;
      end else if (state == led_ctrl_pkg::HST_IDLE) begin
         qcnt  <= 8'h00;
         phase <= 2'h0;
      end else if (tick) begin
         qcnt  <= 8'h00;
         phase <= phase + 2'h1;
      end else begin
         qcnt <= qcnt + 8'h01;
      end
   end

   // status flags, cleared by a new start
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done <= 1'b0;
         nack <= 1'b0;
      end else if (state == led_ctrl_pkg::HST_STOP && tick && phase == 2'h3) begin
         done <= 1'b1;
         nack <= ack_bad;
      end else if (go) begin
         done <= 1'b0;
         nack <= 1'b0;
      end
   end

   // link engine
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= led_ctrl_pkg::HST_IDLE;
         link.scl <= 1'b1;
         sda_lvl  <= 1'b1;
         bit_idx  <= 4'h0;
         byte_idx <= 2'h0;
         tx       <= 8'h00;
         ack_bad  <= 1'b0;
      end else begin
         case (state)
            led_ctrl_pkg::HST_IDLE: begin
               if (go) begin
                  state    <= led_ctrl_pkg::HST_START;
                  tx       <= {cmd[6:0], 1'b0};
                  bit_idx  <= 4'h0;
                  byte_idx <= 2'h0;
                  ack_bad  <= 1'b0;
               end
            end
            led_ctrl_pkg::HST_START: begin
               if (tick) begin
                  if (phase == 2'h0) begin
                     sda_lvl <= 1'b0;
                  end else if (phase == 2'h3) begin
                     link.scl <= 1'b0;
                     state    <= led_ctrl_pkg::HST_BIT;
                  end
               end
            end
            led_ctrl_pkg::HST_BIT: begin
               if (tick) begin
                  if (phase == 2'h0) begin
                     sda_lvl <= (bit_idx < 4'h8) ? tx[7] : 1'b1;
                  end else if (phase == 2'h1) begin
                     link.scl <= 1'b1;
                  end else if (phase == 2'h2) begin
                     if (bit_idx == 4'h8) begin
                        ack_bad <= sda_s;
                     end
                  end else begin
                     link.scl <= 1'b0;
                     if (bit_idx < 4'h8) begin
                        tx      <= {tx[6:0], 1'b0};
                        bit_idx <= bit_idx + 4'h1;
                     end else begin
                        bit_idx <= 4'h0;
                        if (ack_bad || byte_idx == 2'h2) begin
                           state <= led_ctrl_pkg::HST_STOP;
                        end else begin
                           byte_idx <= byte_idx + 2'h1;
                           tx       <= (byte_idx == 2'h0) ? cmd[15:8] : cmd[23:16];
                        end
                     end
                  end
               end
            end
            led_ctrl_pkg::HST_STOP: begin
               if (tick) begin
                  if (phase == 2'h0) begin
                     sda_lvl <= 1'b0;
                  end else if (phase == 2'h1) begin
                     link.scl <= 1'b1;
                  end else if (phase == 2'h2) begin
                     sda_lvl <= 1'b1;
                  end else begin
                     state <= led_ctrl_pkg::HST_IDLE;
                  end
               end
            end
            default: begin
               state <= led_ctrl_pkg::HST_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== sim/led_ctrl_assertions.sv ====
/*
 link checks: start/stop, busy flag, ack timing, reset pin.
 assumes the link signals and the device busy flag, sampled on mclk_i.
*/
`timescale 1ns/1ps
module led_ctrl_assertions (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_oe,
   input wire logic reset_n,
   input wire logic bus_busy_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence
   start_busy_a: assert property (start_s |-> ##[1:6] bus_busy_o)
      else $error("busy not set after start");
   stop_free_a: assert property (stop_s |-> ##[1:6] !bus_busy_o)
      else $error("busy not cleared after stop");
   busy_cause_a: assert property ($rose(bus_busy_o) |-> scl && !sda)
      else $error("busy rose without start");
   free_cause_a: assert property ($fell(bus_busy_o) && reset_n |-> scl && sda)
      else $error("busy fell without stop");
   data_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
      else $error("device data moved while clock high");
   ack_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("device data edge with clock high");
   ack_pulse_a: assert property ($rose(s_sda_oe) |->
      s_sda_oe throughout (##[1:40] $rose(scl) ##[1:40] $fell(scl)))
      else $error("ack not held over ninth pulse");
   ack_busy_a: assert property (s_sda_oe |-> bus_busy_o)
      else $error("ack outside a transaction");
   pin_reset_a: assert property (!reset_n |-> ##[1:2] !s_sda_oe && !bus_busy_o)
      else $error("reset pin did not clear link");
endmodule

// ==== sim/tb.sv ====
/*
 bench: apb tasks order link writes from host to device; outputs compared.
 assumes the host and device ends joined by led_ctrl_if.
*/
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module tb;
   logic        mclk_i = 1'h0;
   logic        rst_n_i = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err;
   logic [4:0]  main_low = 5'h00, main_on;
   logic [2:0]  aux_low = 3'h0, aux_on;
   logic [1:0]  main_lvl, aux_lvl, ind_lvl;
   logic        ind_on, gain, busy;
   logic [7:0]  codes [4] = '{8'h0F, 8'h1C, 8'h1D, 8'h10};
   logic [7:0]  lvls [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
   int          num_errors = 0, checks_done = 0, n;
   always #5 mclk_i = ~mclk_i;
   led_ctrl_if link();
   led_ctrl_host #(.QUARTER(8)) led_ctrl_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .link(link.master), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr));
   led_ctrl_device #(.SELECT_ALT_ADDR(1'h0), .PWM_CYCLES(32)) led_ctrl_device_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link.device), .main_sense_low_i(main_low),
      .aux_sense_low_i(aux_low), .main_sink_on_o(main_on), .main_level_o(main_lvl),
      .aux_sink_on_o(aux_on), .aux_level_o(aux_lvl), .indicator_on_o(ind_on),
      .indicator_level_o(ind_lvl), .gain_boost_o(gain), .bus_busy_o(busy));
   led_ctrl_assertions led_ctrl_assertions_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .scl(link.scl), .sda(link.sda), .s_sda_oe(link.s_sda_oe), .reset_n(link.reset_n),
      .bus_busy_o(busy));
   task finish_test;
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (pready !== 1'h1) begin
         num_errors++;
         $display("[FAIL] pready expected 1 seen %b", pready);
         finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task send(input logic [6:0] sa, input logic [7:0] r, input logic [7:0] d, input logic nk);
      int k;
      apb(1'h1, `HOST_CMD_OFS, {8'h00, d, r, 1'h0, sa});
      apb(1'h1, `HOST_CTRL_OFS, 32'h1);
      k = 0;
      do begin
         apb(1'h0, `HOST_STATUS_OFS, 32'h0);
         k++;
      end while ((rd[0] !== 1'h0 || rd[2] !== 1'h1) && k < 2000);
      if (rd[0] !== 1'h0 || rd[2] !== 1'h1) begin
         num_errors++;
         $display("[FAIL] done expected 1 seen %b", rd[2]);
         finish_test;
      end
      chk("nack", 8'(nk), 8'(rd[1]));
   endtask
   task settle(input logic [7:0] g);
      repeat (10) @(posedge mclk_i);
      chk("gain", g, 8'(gain));
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'h1;
      repeat (4) @(posedge mclk_i);
      chk("busy", 8'h00, 8'(busy));
      chk("main level", 8'h00, 8'(main_lvl));
      apb(1'h0, 12'h0FC, 32'h0);
      chk("pslverr", 8'h01, 8'(err));
      main_low <= 5'h1F;
      aux_low <= 3'h7;
      settle(8'h00);
      main_low <= 5'h00;
      aux_low <= 3'h0;
      send(`SLAVE_ADDR_STD, `REG_GP_OFS, 8'h01, 1'h0);
      main_low <= 5'h10;
      settle(8'h00);
      main_low <= 5'h01;
      settle(8'h01);
      main_low <= 5'h00;
      send(`SLAVE_ADDR_STD, `REG_GP_OFS, 8'h00, 1'h0);
      settle(8'h00);
      send(`SLAVE_ADDR_STD, `REG_GP_OFS, 8'h02, 1'h0);
      settle(8'h00);
      aux_low <= 3'h4;
      settle(8'h00);
      aux_low <= 3'h1;
      settle(8'h01);
      aux_low <= 3'h0;
      send(`SLAVE_ADDR_STD, `REG_GP_OFS, 8'h07, 1'h0);
      chk("indicator on", 8'h01, 8'(ind_on));
      for (int i = 0; i < 4; i++) begin
         send(`SLAVE_ADDR_STD, `REG_MAIN_OFS, codes[i], 1'h0);
         chk("main level", lvls[i], 8'(main_lvl));
      end
      n = 0;
      repeat (32) begin
         @(posedge mclk_i);
         if (main_on === 5'h1F) n++;
      end
      chk("main duty", 8'h14, 8'(n));
      send(`SLAVE_ADDR_STD, `REG_AUX_OFS, 8'h1F, 1'h0);
      chk("aux level", 8'h03, 8'(aux_lvl));
      chk("aux sinks", 8'h03, 8'(aux_on));
      send(`SLAVE_ADDR_STD, `REG_IND_OFS, 8'h02, 1'h0);
      chk("indicator level", 8'h02, 8'(ind_lvl));
      send(7'h2B, `REG_MAIN_OFS, 8'h1F, 1'h1);
      chk("main level", 8'h01, 8'(main_lvl));
      send(`SLAVE_ADDR_STD, 8'h20, 8'h1F, 1'h0);
      chk("main level", 8'h01, 8'(main_lvl));
      chk("aux level", 8'h03, 8'(aux_lvl));
      apb(1'h1, `HOST_CTRL_OFS, 32'h2);
      repeat (4) @(posedge mclk_i);
      chk("main level", 8'h00, 8'(main_lvl));
      chk("indicator on", 8'h00, 8'(ind_on));
      chk("gain", 8'h00, 8'(gain));
      apb(1'h1, `HOST_CTRL_OFS, 32'h0);
      repeat (4) @(posedge mclk_i);
      chk("aux level", 8'h00, 8'(aux_lvl));
      chk("indicator on", 8'h00, 8'(ind_on));
      finish_test;
   end
endmodule
